// [verif/spmp_checker.sv]
`timescale 1ns/1ps
module spmp_checker
    import spmp_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        global_irq_en,
    input wire logic        irq,
    input wire logic        ss_n_i,
    input wire logic        mosi_oe,
    input wire logic        miso_oe,
    input wire logic        sck_oe,
    input wire logic        ss_n_o,
    input wire logic        ss_n_oe
);
    logic [4:0] pins_q;
    logic       map_ok;
    assign map_ok = paddr inside {SPMP_ADDR_CTRL, SPMP_ADDR_STAT, SPMP_ADDR_DATA, SPMP_ADDR_PINS};
    // ==========================================
    // shadow of the pin-direction register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pins_q <= 5'h00;
        end else if (pready && pwrite && paddr == SPMP_ADDR_PINS) begin
            pins_q <= pwdata[4:0];
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ==========================================
    // properties
    property p_wait;
        $rose(penable) && psel |-> !pready ##1 pready;
    endproperty
    a_wait: assert property (p_wait) else $error("late or early ready");
    property p_pulse;
        pready |=> !pready;
    endproperty
    a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
    property p_err;
        pready |-> pslverr == !map_ok;
    endproperty
    a_err: assert property (p_err) else $error("wrong error response");
    property p_rsvd;
        pready && !pwrite && paddr == SPMP_ADDR_STAT |-> prdata[5:1] == 5'h00;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved status bits set");
    property p_upper;
        pready && !pwrite |-> prdata[31:8] == 24'h000000;
    endproperty
    a_upper: assert property (p_upper) else $error("upper read bits set");
    property p_irq;
        !global_irq_en |=> !irq;
    endproperty
    a_irq: assert property (p_irq) else $error("irq without global enable");
    property p_fault;
        (!pins_q[3] && !ss_n_i) [*4] |-> !mosi_oe && !sck_oe;
    endproperty
    a_fault: assert property (p_fault) else $error("drives while selected");
    property p_idle;
        ss_n_i [*4] |-> !miso_oe;
    endproperty
    a_idle: assert property (p_idle) else $error("data out drives while idle");
    property p_gpo;
        ss_n_oe && $past(pins_q[4]) == pins_q[4] |-> ss_n_o == pins_q[4];
    endproperty
    a_gpo: assert property (p_gpo) else $error("select output wrong");
endmodule
bind spmp_top spmp_checker spmp_checker_i (.*);

// [verif/spmp_partner.sv]
`timescale 1ns/1ps
// ==========================================
// external slave, mode set by the bench
module spmp_partner (
    input  wire logic       sck,
    input  wire logic       ss_n,
    input  wire logic       mosi,
    input  wire logic       cpol,
    input  wire logic       cpha,
    input  wire logic       lsbf,
    input  wire logic [7:0] tx,
    output logic            miso,
    output logic [7:0]      rx
);
    logic [7:0] sr;
    logic       smp;
    logic       last;
    always @(negedge ss_n) begin
        sr = tx;
        smp = 1'b0;
    end
    always @(sck) begin
        if (!ss_n && (sck ^ cpol ^ cpha)) begin
            rx = lsbf ? {mosi, rx[7:1]} : {rx[6:0], mosi};
            smp = 1'b1;
        end else if (!ss_n && smp) begin
            sr = lsbf ? sr >> 1 : sr << 1;
            smp = 1'b0;
        end
    end
    // released line flips so a stale bit never passes
    always @* if (!ss_n) last = lsbf ? sr[0] : sr[7];
    assign miso = ss_n ? ~last : (lsbf ? sr[0] : sr[7]);
endmodule

// [verif/spmp_top_tb.sv]
`timescale 1ns/1ps
module spmp_top_tb;
    import spmp_pkg::*;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        global_irq_en = 1'b0, irq_ack = 1'b0, sck_i = 1'b0, mosi_i = 1'b0;
    logic        ss_n_i = 1'b1, cpol = 1'b0, cpha = 1'b0, lsbf = 1'b0;
    logic        pready, pslverr, irq, sck_o, sck_oe, mosi_o, mosi_oe, miso_i;
    logic        miso_o, miso_oe, ss_n_o, ss_n_oe, sck_p, e;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r, s = 32'h00013047;
    logic [7:0]  ptx = 8'h00, prx, b, m, got;
    int          n_mismatch = 0, n_tests = 0, edges = 0, gap = 0, cyc = 0;
    spmp_top spmp_top_i (.*);
    spmp_partner spmp_partner_i (.sck(sck_o), .ss_n(ss_n_o), .mosi(mosi_o), .cpol(cpol),
        .cpha(cpha), .lsbf(lsbf), .tx(ptx), .miso(miso_i), .rx(prx));
    initial begin
        forever #2 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        sck_p <= sck_o;
        if (sck_o !== sck_p) begin
            edges++;
            gap = cyc;
            cyc = 0;
        end
    end
    // ==========================================
    // helpers
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function automatic int half(input logic [1:0] rt, input logic db);
        int t[4] = '{2, 8, 32, 64};
        return db ? t[rt] / 2 : t[rt];
    endfunction
    task automatic end_of_test;
        if (n_mismatch == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        n_tests++;
        if (g !== x) begin
            n_mismatch++;
            $display("BAD %0t got %h expected %h", $time, g, x);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        int k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 20) begin
            n_mismatch++;
            end_of_test;
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 8'h00);
        chk(r, x);
    endtask
    task automatic wait_done;
        int k = 0;
        do begin
            apb(1'b0, SPMP_ADDR_STAT, 8'h00);
            k++;
        end while (r[7] !== 1'b1 && k < 400);
        if (k >= 400) begin
            n_mismatch++;
            end_of_test;
        end
    endtask
    // slow external master, mode 0, msb first
    task automatic xfer(input logic [7:0] d, input int nb);
        ss_n_i <= 1'b0;
        for (int i = 7; i >= 8 - nb; i--) begin
            mosi_i <= d[i];
            repeat (4) @(posedge pclk);
            got = {got[6:0], miso_o};
            sck_i <= 1'b1;
            repeat (4) @(posedge pclk);
            sck_i <= 1'b0;
        end
        repeat (4) @(posedge pclk);
        chk(miso_oe, 1'b1);
    endtask
    // ==========================================
    // main sequence
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rdc(SPMP_ADDR_CTRL, 32'h0);
        rdc(SPMP_ADDR_STAT, 32'h0);
        rdc(12'h010, 32'h0);
        chk(e, 1'b1);
        wr(SPMP_ADDR_STAT, 8'h3f);
        rdc(SPMP_ADDR_STAT, 32'h1);
        for (int i = 0; i < 8; i++) begin
            s = nxt(s);
            b = s[7:0];
            ptx <= s[15:8];
            {lsbf, cpol, cpha} <= i[2:0];
            wr(SPMP_ADDR_PINS, 8'h1d);
            wr(SPMP_ADDR_STAT, {7'h00, s[18]});
            wr(SPMP_ADDR_CTRL, {2'b01, i[2], 1'b1, i[1:0], s[17:16]});
            wr(SPMP_ADDR_PINS, 8'h0d);
            edges = 0;
            wr(SPMP_ADDR_DATA, b);
            wait_done;
            chk(edges, 16);
            chk(gap, half(s[17:16], s[18]));
            chk(prx, b);
            chk(r, {24'h0, 1'b1, 6'h00, s[18]});
            rdc(SPMP_ADDR_DATA, {24'h0, ptx});
            rdc(SPMP_ADDR_STAT, {31'h0, s[18]});
        end
        lsbf <= 1'b0;
        wr(SPMP_ADDR_PINS, 8'h1d);
        wr(SPMP_ADDR_PINS, 8'h0d);
        wr(SPMP_ADDR_STAT, 8'h00);
        wr(SPMP_ADDR_CTRL, 8'h5f);
        wr(SPMP_ADDR_DATA, 8'h5a);
        wr(SPMP_ADDR_DATA, 8'ha5);
        rdc(SPMP_ADDR_STAT, 32'h40);
        wait_done;
        chk(r, 32'hc0);
        chk(prx, 8'h5a);
        rdc(SPMP_ADDR_DATA, {24'h0, ptx});
        rdc(SPMP_ADDR_STAT, 32'h0);
        wr(SPMP_ADDR_CTRL, 8'h1f);
        repeat (4) @(posedge pclk);
        edges = 0;
        wr(SPMP_ADDR_DATA, 8'h3c);
        repeat (300) @(posedge pclk);
        chk(edges, 0);
        rdc(SPMP_ADDR_STAT, 32'h0);
        wr(SPMP_ADDR_PINS, 8'h05);
        global_irq_en <= 1'b1;
        wr(SPMP_ADDR_CTRL, 8'hd0);
        ss_n_i <= 1'b0;
        repeat (6) @(posedge pclk);
        chk(irq, 1'b1);
        rdc(SPMP_ADDR_CTRL, 32'hc0);
        irq_ack <= 1'b1;
        @(posedge pclk);
        irq_ack <= 1'b0;
        repeat (2) @(posedge pclk);
        chk(irq, 1'b0);
        rdc(SPMP_ADDR_STAT, 32'h0);
        ss_n_i <= 1'b1;
        rdc(SPMP_ADDR_CTRL, 32'hc0);
        global_irq_en <= 1'b0;
        wr(SPMP_ADDR_PINS, 8'h02);
        wr(SPMP_ADDR_CTRL, 8'h40);
        xfer(8'hff, 3);
        ss_n_i <= 1'b1;
        rdc(SPMP_ADDR_STAT, 32'h0);
        wr(SPMP_ADDR_DATA, 8'h96);
        s = nxt(s);
        m = s[7:0];
        xfer(m, 8);
        chk(got, 8'h96);
        xfer(~m, 8);
        ss_n_i <= 1'b1;
        wait_done;
        rdc(SPMP_ADDR_DATA, {24'h0, ~m});
        end_of_test;
    end
endmodule

// [verilog/spmp_clkdiv.sv]
`timescale 1ns/1ps
// half-period enable generator for the master serial clock
module spmp_clkdiv
    import spmp_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       run,
    input  wire logic [1:0] rate,
    input  wire logic       dbl,
    output logic            tick
);
    typedef struct packed {
        logic [6:0] cnt;
        logic       tick;
    } spmp_div_s;

    spmp_div_s q, d;
    logic [6:0] half;

    always_comb begin
        case ({dbl, rate})
            3'b000:  half = SPMP_HALF_4;
            3'b001:  half = SPMP_HALF_16;
            3'b010:  half = SPMP_HALF_64;
            3'b011:  half = SPMP_HALF_128;
            3'b100:  half = SPMP_HALF_2;
            3'b101:  half = SPMP_HALF_8;
            3'b110:  half = SPMP_HALF_32;
            default: half = SPMP_HALF_64;
        endcase
        d = q;
        d.tick = 1'b0;
        if (!run) begin
            d.cnt = 7'h00;
        end else if (q.cnt >= half - 7'h01) begin
            d.cnt  = 7'h00;
            d.tick = 1'b1;
        end else begin
            d.cnt = q.cnt + 7'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tick = q.tick;
endmodule

// [verilog/spmp_pkg.sv]
package spmp_pkg;
    // ==========================================
    // register map (byte addresses)
    localparam logic [11:0] SPMP_ADDR_CTRL = 12'h000;
    localparam logic [11:0] SPMP_ADDR_STAT = 12'h004;
    localparam logic [11:0] SPMP_ADDR_DATA = 12'h008;
    localparam logic [11:0] SPMP_ADDR_PINS = 12'h00c;
    // ==========================================
    // control fields
    localparam int SPMP_CTRL_IE    = 7;
    localparam int SPMP_CTRL_EN    = 6;
    localparam int SPMP_CTRL_LSBF  = 5;
    localparam int SPMP_CTRL_MASTER_SELECT  = 4;
    localparam int SPMP_CTRL_CPOL  = 3;
    localparam int SPMP_CTRL_CPHA  = 2;
    localparam int SPMP_CTRL_RATE1 = 1;
    localparam int SPMP_CTRL_RATE0 = 0;
    // ==========================================
    // status fields
    localparam int SPMP_STAT_DONE = 7;
    localparam int SPMP_STAT_WRITE_COLLISION_FLAG = 6;
    localparam int SPMP_STAT_DBL  = 0;
    // ==========================================
    // pin direction register fields (user-defined directions)
    localparam int SPMP_PIN_MOSI_OE = 0;
    localparam int SPMP_PIN_MISO_OE = 1;
    localparam int SPMP_PIN_SCK_OE  = 2;
    localparam int SPMP_PIN_SS_OE   = 3;
    localparam int SPMP_PIN_SS_VAL  = 4;
    // ==========================================
    // reset values and counts
    localparam logic [7:0] SPMP_CTRL_RST = 8'h00;
    localparam logic [7:0] SPMP_STAT_RST = 8'h00;
    localparam logic [7:0] SPMP_PINS_RST = 8'h00;
    localparam logic [3:0] SPMP_BITS     = 4'h8;
    // half-periods in pclk cycles for divide 2,4,8,16,32,64,128
    localparam logic [6:0] SPMP_HALF_2   = 7'h01;
    localparam logic [6:0] SPMP_HALF_4   = 7'h02;
    localparam logic [6:0] SPMP_HALF_8   = 7'h04;
    localparam logic [6:0] SPMP_HALF_16  = 7'h08;
    localparam logic [6:0] SPMP_HALF_32  = 7'h10;
    localparam logic [6:0] SPMP_HALF_64  = 7'h20;
    localparam logic [6:0] SPMP_HALF_128 = 7'h40;
endpackage

// [verilog/spmp_top.sv]
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/1ps
// What this block does
// - slave role: select is input; low activates port, data-out drives if enabled
// - select high in slave role resets shifter and drops partial byte
// - master with select as output: select is plain general output
// - master with select input low: master bit clears, becomes slave
// - forced switch to slave sets complete flag, may interrupt
// - master bit stays cleared until software writes it again
// - interrupt requested when enable, complete flag and global enable set
// - no serial activity unless port enable is one
// - bit order: one sends LSB first, zero MSB first
// - role bit: one master, zero slave
// - clock polarity: one idles high, zero idles low
// - clock phase: zero samples on leading edge, one on trailing
// - master rate bits pick divide 4/16/64/128, each halved with double speed to 2/8/32/64
// - complete flag sets when a byte transfer completes
// - complete flag clears on vector ack or status read then data access
// - collision flag sets on data write during a transfer
// - status read with collision set then data access clears both flags
// - status bits 5..1 read as zero
// - double speed bit gives shortest serial period of two clocks
// - data write starts transmission; data read returns receive buffer
// - transmit single buffered, receive double buffered with overwrite
// - slave with select high keeps data-out off and stays idle
module spmp_top
    import spmp_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        global_irq_en,
    input  wire logic        irq_ack,
    output logic             irq,
    input  wire logic        sck_i,
    output logic             sck_o,
    output logic             sck_oe,
    input  wire logic        mosi_i,
    output logic             mosi_o,
    output logic             mosi_oe,
    input  wire logic        miso_i,
    output logic             miso_o,
    output logic             miso_oe,
    input  wire logic        ss_n_i,
    output logic             ss_n_o,
    output logic             ss_n_oe
);
    typedef struct packed {
        logic [7:0]  ctrl;
        logic        done;
        logic        write_collision_flag;
        logic        dbl;
        logic [7:0]  pins;
        logic [7:0]  shreg;
        logic [7:0]  rxbuf;
        logic [3:0]  bitcnt;
        logic        busy;
        logic        lead;     // next master edge is a leading edge
        logic        sck_sync;
        logic        sck_prev;
        logic        ss_sync;
        logic        rxbit;
        logic        stat_seen;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        irq;
        logic        sck_o;
        logic        sck_oe;
        logic        mosi_o;
        logic        mosi_oe;
        logic        miso_o;
        logic        miso_oe;
        logic        ss_n_o;
        logic        ss_n_oe;
    } spmp_state_s;

    spmp_state_s q, d;
    logic        tick;
    logic        en, master_select, cpol, cpha, lsbf;
    logic        acc, wr, rd;
    logic        sck_edge, sck_rise, lead_edge, trail_edge;
    logic        sample, setup, finish, serial_in;
    logic [7:0]  shifted;
    logic        ss_low_fault;
    logic        req;
    logic        mapped;
    logic        in_bit;
    logic [31:0] rd_word;

    assign en   = q.ctrl[SPMP_CTRL_EN];
    assign master_select = q.ctrl[SPMP_CTRL_MASTER_SELECT];
    assign cpol = q.ctrl[SPMP_CTRL_CPOL];
    assign cpha = q.ctrl[SPMP_CTRL_CPHA];
    assign lsbf = q.ctrl[SPMP_CTRL_LSBF];
    assign acc  = psel && penable && q.pready;
    assign wr   = acc && pwrite;
    assign rd   = acc && !pwrite;

    // ==========================================
    // bus decode: read data and error are fetched one cycle early
    // so that they stand together with pready; writes and flag
    // clears land later, at the edge that sees pready high
    assign req    = psel && penable && !q.pready;
    assign mapped = (paddr == SPMP_ADDR_CTRL)
                 || (paddr == SPMP_ADDR_STAT)
                 || (paddr == SPMP_ADDR_DATA)
                 || (paddr == SPMP_ADDR_PINS);

    always_comb begin
        case (paddr)
            SPMP_ADDR_CTRL: begin
                rd_word = {24'h000000, q.ctrl};
            end
            SPMP_ADDR_STAT: begin
                rd_word = {24'h000000, q.done, q.write_collision_flag, 5'h00, q.dbl};
            end
            SPMP_ADDR_DATA: begin
                rd_word = {24'h000000, q.rxbuf};
            end
            SPMP_ADDR_PINS: begin
                rd_word = {24'h000000, q.pins};
            end
            // unmapped offsets read as zero
            default: begin
                rd_word = 32'h00000000;
            end
        endcase
    end

    spmp_clkdiv u_div (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (q.busy && master_select && en),
        .rate    (q.ctrl[SPMP_CTRL_RATE1:SPMP_CTRL_RATE0]),
        .dbl     (q.dbl),
        .tick    (tick)
    );

    always_comb begin
        d = q;
        // ==========================================
        // input sampling; sck_prev reads only the first stage
        d.sck_sync = sck_i;
        d.sck_prev = q.sck_sync;
        d.ss_sync  = ss_n_i;

        // ==========================================
        // serial edge decode
        sck_edge   = 1'b0;
        sck_rise   = 1'b0;
        lead_edge  = 1'b0;
        trail_edge = 1'b0;
        ss_low_fault = en && master_select && !q.pins[SPMP_PIN_SS_OE] && !q.ss_sync;
        if (en && master_select) begin
            sck_edge  = tick && q.busy;
            lead_edge = sck_edge && q.lead;
            trail_edge = sck_edge && !q.lead;
        end else if (en && !master_select && !q.ss_sync) begin
            sck_edge = q.sck_sync != q.sck_prev;
            sck_rise = q.sck_sync && !q.sck_prev;
            lead_edge  = sck_edge && (sck_rise ^ cpol);
            trail_edge = sck_edge && !(sck_rise ^ cpol);
        end
        sample = cpha ? trail_edge : lead_edge;
        setup  = cpha ? lead_edge : trail_edge;
        serial_in = master_select ? miso_i : mosi_i;
        // the closing sample of a cpha=1 byte goes straight into the buffer
        in_bit  = sample ? serial_in : q.rxbit;
        shifted = lsbf ? {in_bit, q.shreg[7:1]} : {q.shreg[6:0], in_bit};
        finish = 1'b0;

        // ==========================================
        // shift engine
        if (sample) begin
            d.rxbit  = serial_in;
            d.bitcnt = q.bitcnt + 4'h1;
            if (q.bitcnt == SPMP_BITS - 4'h1 && cpha) begin
                finish = 1'b1;
            end
        end
        if (setup) begin
            if (q.bitcnt == SPMP_BITS && !cpha) begin
                finish = 1'b1;
            end else if (q.bitcnt != 4'h0 || cpha) begin
                d.shreg = (q.bitcnt == 4'h0) ? q.shreg : shifted;
            end
        end
        if (!en && master_select) begin
            d.busy = 1'b0;
        end
        if (en && master_select && sck_edge) begin
            d.lead = !q.lead;
        end
        if (!en && !master_select) begin
            d.busy = 1'b0;
        end
        // slave starts on select low, so first edge finds a bit ready
        if (en && !master_select && !q.ss_sync && !q.busy) begin
            d.busy   = 1'b1;
            d.bitcnt = sample ? 4'h1 : 4'h0;
        end
        if (finish) begin
            d.shreg  = shifted;
            d.rxbuf  = shifted;
            d.busy   = 1'b0;
            d.bitcnt = 4'h0;
            d.lead   = 1'b1;
        end
        if (en && !master_select && q.ss_sync) begin
            d.busy   = 1'b0;
            d.bitcnt = 4'h0;
        end

        // ==========================================
        // register bus
        d.pready  = req;
        d.pslverr = req && !mapped;
        if (req && !pwrite) begin
            d.prdata = rd_word;
        end
        // stat_seen arms the clear: status read with a flag set
        if (req && !pwrite && paddr == SPMP_ADDR_STAT) begin
            d.stat_seen = q.done || q.write_collision_flag;
        end
        if (acc && paddr == SPMP_ADDR_DATA) begin
            if (q.stat_seen) begin
                d.done = 1'b0;
                d.write_collision_flag = 1'b0;
            end
            d.stat_seen = 1'b0;
        end
        if (irq_ack) begin
            d.done = 1'b0;
        end
        if (wr) begin
            case (paddr)
                SPMP_ADDR_CTRL: d.ctrl = pwdata[7:0];
                SPMP_ADDR_STAT: d.dbl  = pwdata[SPMP_STAT_DBL];
                SPMP_ADDR_PINS: d.pins = pwdata[7:0];
                SPMP_ADDR_DATA: begin
                    if (q.busy && !(en && !master_select && q.bitcnt == 4'h0 && !cpha)) begin
                        d.write_collision_flag = 1'b1;
                    end else begin
                        d.shreg = pwdata[7:0];
                        if (en && master_select) begin
                            d.busy   = 1'b1;
                            d.bitcnt = 4'h0;
                            d.lead   = 1'b1;
                        end
                    end
                end
                default: ;
            endcase
        end
        // ==========================================
        // mode fault; hardware sets win over any clear above
        if (ss_low_fault) begin
            d.ctrl[SPMP_CTRL_MASTER_SELECT] = 1'b0;
            d.done = 1'b1;
            d.busy = 1'b0;
            d.bitcnt = 4'h0;
        end
        if (finish) begin
            d.done = 1'b1;
        end

        // ==========================================
        // pins
        d.irq = d.ctrl[SPMP_CTRL_IE] && d.done && global_irq_en;
        if (!(en && master_select)) begin
            d.lead = 1'b1;
        end
        if (d.ctrl[SPMP_CTRL_EN] && d.ctrl[SPMP_CTRL_MASTER_SELECT]) begin
            d.sck_oe  = d.pins[SPMP_PIN_SCK_OE];
            d.mosi_oe = d.pins[SPMP_PIN_MOSI_OE];
            d.miso_oe = 1'b0;
        end else if (d.ctrl[SPMP_CTRL_EN]) begin
            d.sck_oe  = 1'b0;
            d.mosi_oe = 1'b0;
            d.miso_oe = d.pins[SPMP_PIN_MISO_OE] && !q.ss_sync;
        end else begin
            d.sck_oe  = d.pins[SPMP_PIN_SCK_OE];
            d.mosi_oe = d.pins[SPMP_PIN_MOSI_OE];
            d.miso_oe = d.pins[SPMP_PIN_MISO_OE];
        end
        // idle level = polarity; toggles on each master half period
        if (en && master_select && q.busy && sck_edge) begin
            d.sck_o = !q.sck_o;
        end else if (!(q.busy && en && master_select)) begin
            d.sck_o = cpol;
        end

        // a cpha=1 byte ends on a sample edge; hold data-out there
        if (!(finish && cpha)) begin
            d.mosi_o = lsbf ? d.shreg[0] : d.shreg[7];
        end
        d.miso_o = d.mosi_o;
        // select follows software value only; port logic ignores it
        d.ss_n_o  = d.pins[SPMP_PIN_SS_VAL];
        d.ss_n_oe = d.ctrl[SPMP_CTRL_MASTER_SELECT] && d.pins[SPMP_PIN_SS_OE];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q        <= '0;
            q.ctrl   <= SPMP_CTRL_RST;
            q.pins   <= SPMP_PINS_RST;
            q.lead   <= 1'b1;
            q.ss_sync <= 1'b1;
            q.ss_n_o <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign prdata  = q.prdata;
    assign pready  = q.pready;
    assign pslverr = q.pslverr;
    assign irq     = q.irq;
    assign sck_o   = q.sck_o;
    assign sck_oe  = q.sck_oe;
    assign mosi_o  = q.mosi_o;
    assign mosi_oe = q.mosi_oe;
    assign miso_o  = q.miso_o;
    assign miso_oe = q.miso_oe;
    assign ss_n_o  = q.ss_n_o;
    assign ss_n_oe = q.ss_n_oe;
endmodule
